// >>> include/logic_exec_pkg.sv
/*
  Constants and carrier types for the logic/swap/direction execution block.
  Assumes a core that fetches and decodes, then hands one operation per
  cycle to this block together with the file operand; the accumulator is held in this block.
*/
package logic_exec_pkg;

  localparam int          DATA_W        = 8;
  localparam int          FADDR_W       = 7;
  localparam int          FADDR_MAX     = 127;
  localparam logic [2:0]  DIR_SEL_A     = 3'h5;
  localparam logic [2:0]  DIR_SEL_B     = 3'h6;
  localparam logic [2:0]  DIR_SEL_C     = 3'h7;
  localparam logic [7:0]  ACCUM_RESET   = 8'h00;
  localparam logic [7:0]  DIR_RESET     = 8'hff;
  localparam logic        DEST_ACCUM    = 1'b0;
  localparam logic        DEST_FILE     = 1'b1;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_OR_ACCUM_WITH_FILE,
    OP_SWAP_NIBBLES_FILE,
    OP_XOR_LITERAL_ACCUM,
    OP_LOAD_DIRECTION_REG,
    OP_XOR_ACCUM_WITH_FILE
  } op_t;

  // One issued instruction
  typedef struct packed {
    logic         valid;
    op_t          op;
    logic         dest;
    logic [6:0]   faddr;
    logic [7:0]   literal;
    logic [7:0]   fdata;
  } instr_t;

  // Write-back towards the file register space
  typedef struct packed {
    logic         we;
    logic [6:0]   addr;
    logic [7:0]   data;
  } file_wr_t;

endpackage

// >>> rtl/direction_regs.sv
/*
  Three port direction registers with registered outputs.
  Assumes writes come from the execution unit, one per cycle at most.
*/
module direction_regs
  import logic_exec_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             we,
  input  wire logic [2:0]       sel,
  input  wire logic [WIDTH-1:0] wdata,
  output logic      [WIDTH-1:0] dir_q [3]
);
  import logic_exec_pkg::*;

  // Only the 8-bit direction registers are built
  if (WIDTH != DATA_W) begin : g_width_check
    $error("direction_regs: WIDTH must equal DATA_W");
  end

  localparam logic [2:0] SEL_CODE [3] = '{DIR_SEL_A, DIR_SEL_B, DIR_SEL_C};

  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_dir
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          dir_q[i] <= DIR_RESET;
        end else if (we && sel == SEL_CODE[i]) begin
          dir_q[i] <= wdata;
        end
      end
    end
  endgenerate

endmodule

// >>> rtl/logic_swap_load_direction_reg_instr_exec.sv
/*
  Execution datapath for OR, XOR, nibble swap and direction load.
  Assumes the core presents the file operand already read from the
  addressed register and applies file_wr itself one cycle later.
*/
module logic_swap_load_direction_reg_instr_exec
  import logic_exec_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic                      clk,
  input  wire logic                      rstn,
  input  wire logic_exec_pkg::instr_t    instr,
  output logic      [7:0]                accum,
  output logic                           zero_flag,
  output logic_exec_pkg::file_wr_t       file_wr,
  output logic      [7:0]                port_a_direction,
  output logic      [7:0]                port_b_direction,
  output logic      [7:0]                port_c_direction
);
  import logic_exec_pkg::*;

  // The datapath and flag logic are only built for 8 bits
  if (WIDTH != DATA_W) begin : g_width_check
    $error("exec: WIDTH must equal DATA_W");
  end

  // ****************************************************************
  // Result and routing
  // ****************************************************************
  logic [7:0] next_result;
  logic       to_file;
  logic       to_accum;
  logic       sets_zero;
  logic       dir_we;
  logic [7:0] dir_q [3];

  always_comb begin
    next_result = 8'h00;
    to_file     = 1'b0;
    to_accum    = 1'b0;
    sets_zero   = 1'b0;
    dir_we      = 1'b0;
    if (instr.valid) begin
      case (instr.op)
        OP_OR_ACCUM_WITH_FILE: begin
          next_result = accum | instr.fdata;
          to_file     = instr.dest == DEST_FILE;
          to_accum    = instr.dest == DEST_ACCUM;
          sets_zero   = 1'b1;
        end
        OP_SWAP_NIBBLES_FILE: begin
          next_result = {instr.fdata[3:0], instr.fdata[7:4]};
          to_file     = instr.dest == DEST_FILE;
          to_accum    = instr.dest == DEST_ACCUM;
        end
        OP_XOR_LITERAL_ACCUM: begin
          next_result = accum ^ instr.literal;
          to_accum    = 1'b1;
          sets_zero   = 1'b1;
        end
        // direction load; operand outside 5..7 is a no-op
        OP_LOAD_DIRECTION_REG: begin
          next_result = accum;
          dir_we      = instr.faddr[2:0] >= DIR_SEL_A &&
                        instr.faddr[6:3] == 4'h0;
        end
        OP_XOR_ACCUM_WITH_FILE: begin
          next_result = accum ^ instr.fdata;
          to_file     = instr.dest == DEST_FILE;
          to_accum    = instr.dest == DEST_ACCUM;
          sets_zero   = 1'b1;
        end
        default: begin
          next_result = 8'h00;
        end
      endcase
    end
  end

  // ****************************************************************
  // Accumulator
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      accum <= ACCUM_RESET;
    end else if (to_accum) begin
      accum <= next_result;
    end
  end

  // ****************************************************************
  // Zero flag
  // ****************************************************************
  // zero from result
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      zero_flag <= 1'b0;
    end else if (sets_zero) begin
      zero_flag <= next_result == 8'h00;
    end
  end

  // ****************************************************************
  // File write-back
  // ****************************************************************
  // seven-bit address passthrough
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      file_wr <= '0;
    end else begin
      file_wr.we   <= to_file;
      file_wr.addr <= instr.faddr;
      file_wr.data <= next_result;
    end
  end

  // ****************************************************************
  // Direction registers
  // ****************************************************************
  direction_regs #(
    .WIDTH (WIDTH)
  ) i_direction_regs (
    .clk   (clk),
    .rstn  (rstn),
    .we    (dir_we),
    .sel   (instr.faddr[2:0]),
    .wdata (accum),
    .dir_q (dir_q)
  );

  // Flop copies keep top outputs registered; costs one cycle of latency
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      port_a_direction <= DIR_RESET;
      port_b_direction <= DIR_RESET;
      port_c_direction <= DIR_RESET;
    end else begin
      port_a_direction <= dir_q[0];
      port_b_direction <= dir_q[1];
      port_c_direction <= dir_q[2];
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_or_file_issued;
    instr.valid && instr.op == OP_OR_ACCUM_WITH_FILE;
  endsequence

  sequence s_dir_a_issued;
    instr.valid && instr.op == OP_LOAD_DIRECTION_REG && instr.faddr == 7'h05;
  endsequence

  // An invalid slot or an empty opcode is a bubble
  sequence s_idle_issued;
    !instr.valid || instr.op == OP_NONE;
  endsequence

  AST_OR_DEST: assert property (@(posedge clk) disable iff (!rstn)
    s_or_file_issued |=>
      ($past(instr.dest) ? (file_wr.we &&
        file_wr.data == ($past(accum) | $past(instr.fdata)))
      : (accum == ($past(accum) | $past(instr.fdata)) && !file_wr.we)))
    else $error("OR result misrouted");

  AST_SWAP: assert property (@(posedge clk) disable iff (!rstn)
    instr.valid && instr.op == OP_SWAP_NIBBLES_FILE |=>
      $stable(zero_flag) && (file_wr.data ==
        {$past(instr.fdata[3:0]), $past(instr.fdata[7:4])}))
    else $error("swap wrong or flag changed");

  AST_XORL: assert property (@(posedge clk) disable iff (!rstn)
    instr.valid && instr.op == OP_XOR_LITERAL_ACCUM |=>
      accum == ($past(accum) ^ $past(instr.literal)) && !file_wr.we)
    else $error("XOR literal wrong");

  AST_DIR_A: assert property (@(posedge clk) disable iff (!rstn)
    s_dir_a_issued |=> $stable(zero_flag) ##1
      port_a_direction == $past(accum, 2))
    else $error("port A direction not loaded");

  AST_XORF: assert property (@(posedge clk) disable iff (!rstn)
    instr.valid && instr.op == OP_XOR_ACCUM_WITH_FILE && instr.dest |=>
      file_wr.we && file_wr.data == ($past(accum) ^ $past(instr.fdata)))
    else $error("XOR file write-back wrong");

  AST_ADDR: assert property (@(posedge clk) disable iff (!rstn)
    instr.valid && instr.op == OP_SWAP_NIBBLES_FILE && instr.dest |=>
      file_wr.we && file_wr.addr == $past(instr.faddr))
    else $error("swap address wrong");

  // Zero is judged from the operands so a wrong result net is caught
  AST_ZERO: assert property (@(posedge clk) disable iff (!rstn)
    s_or_file_issued |=>
      zero_flag == (($past(accum) | $past(instr.fdata)) == 8'h00))
    else $error("zero flag wrong after OR");

  AST_ZERO_XL: assert property (@(posedge clk) disable iff (!rstn)
    instr.valid && instr.op == OP_XOR_LITERAL_ACCUM |=>
      zero_flag == (($past(accum) ^ $past(instr.literal)) == 8'h00))
    else $error("zero flag wrong after XOR literal");

  AST_ZERO_XF: assert property (@(posedge clk) disable iff (!rstn)
    instr.valid && instr.op == OP_XOR_ACCUM_WITH_FILE |=>
      zero_flag == (($past(accum) ^ $past(instr.fdata)) == 8'h00))
    else $error("zero flag wrong after XOR file");

  AST_NOFLAG: assert property (@(posedge clk) disable iff (!rstn)
    instr.valid && instr.op == OP_LOAD_DIRECTION_REG |=>
      $stable(zero_flag) && $stable(accum) && !file_wr.we)
    else $error("direction load disturbed state");

  // Out-of-range operands must leave every direction register alone
  AST_DIR_BAD: assert property (@(posedge clk) disable iff (!rstn)
    instr.valid && instr.op == OP_LOAD_DIRECTION_REG &&
      !(instr.faddr inside {[7'h05:7'h07]}) |=>
      $stable(dir_q[0]) && $stable(dir_q[1]) && $stable(dir_q[2]))
    else $error("direction register loaded by bad operand");

  AST_SWAP_ACC: assert property (@(posedge clk) disable iff (!rstn)
    instr.valid && instr.op == OP_SWAP_NIBBLES_FILE && !instr.dest |=>
      accum == {$past(instr.fdata[3:0]), $past(instr.fdata[7:4])} &&
      !file_wr.we)
    else $error("swap into accumulator wrong");

  // A bubble must not disturb the accumulator, the flag or the file
  AST_IDLE: assert property (@(posedge clk) disable iff (!rstn)
    s_idle_issued |=> $stable(accum) && $stable(zero_flag) && !file_wr.we)
    else $error("idle slot changed state");

endmodule

// >>> tb/tb_top.sv
/*
  Self-checking bench for the logic, swap and direction execution block.
  Assumes logic_exec_pkg is compiled first; assertions sit in the design.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import logic_exec_pkg::*;

  typedef struct packed {
    logic [7:0]  acc;
    logic        z;
    file_wr_t    wr;
    logic [23:0] dir;
  } note_t;

  logic       clk;
  logic       rstn;
  instr_t     instr;
  logic [7:0] accum;
  logic       zero_flag;
  file_wr_t   file_wr;
  logic [7:0] pa;
  logic [7:0] pb;
  logic [7:0] pc;
  note_t      q [$];
  note_t      cur;
  logic [7:0] m_acc;
  logic [7:0] m_dir [3];
  logic       m_z;
  int         r;
  int         bad_count;
  int         checks;
  int         seed;

  logic_swap_load_direction_reg_instr_exec i_logic_swap_load_direction_reg_instr_exec (
    .clk              (clk),
    .rstn             (rstn),
    .instr            (instr),
    .accum            (accum),
    .zero_flag        (zero_flag),
    .file_wr          (file_wr),
    .port_a_direction (pa),
    .port_b_direction (pb),
    .port_c_direction (pc)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ****************************************
  // Checking and closing
  // ****************************************
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("Counts: checks=%0d mismatches=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Note k falls due once note k+1 exists: outputs lag one cycle
  always @(negedge clk) begin
    while (q.size() > 1) begin
      cur = q.pop_front();
      check(24'(accum), 24'(cur.acc));
      check(24'(zero_flag), 24'(cur.z));
      check(24'(file_wr.we), 24'(cur.wr.we));
      if (cur.wr.we) check(24'(file_wr[14:0]), 24'(cur.wr[14:0]));
      check({pa, pb, pc}, cur.dir);
    end
  end

  // ****************************************
  // Driver and reference model
  // ****************************************
  task automatic issue(input logic v, input op_t op, input logic d,
                       input logic [6:0] fa, input logic [7:0] lit, fd);
    logic [7:0] res;
    note_t n;
    @(posedge clk);
    instr <= '{v, op, d, fa, lit, fd};
    // Directions lag one op behind the accumulator
    n.dir = {m_dir[0], m_dir[1], m_dir[2]};
    n.wr = '0;
    res = 8'h00;
    if (v) case (op)
      OP_OR_ACCUM_WITH_FILE: res = m_acc | fd;
      OP_XOR_ACCUM_WITH_FILE: res = m_acc ^ fd;
      OP_SWAP_NIBBLES_FILE: res = {fd[3:0], fd[7:4]};
      OP_XOR_LITERAL_ACCUM: res = m_acc ^ lit;
      OP_LOAD_DIRECTION_REG: if (fa >= 5 && fa <= 7) m_dir[fa - 7'd5] = m_acc;
      default: ;
    endcase
    if (v && op != OP_NONE && op != OP_LOAD_DIRECTION_REG) begin
      if (d && op != OP_XOR_LITERAL_ACCUM) n.wr = {1'b1, fa, res};
      else m_acc = res;
      if (op != OP_SWAP_NIBBLES_FILE) m_z = (res == 8'h00);
    end
    n.acc = m_acc;
    n.z = m_z;
    q.push_back(n);
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    seed = 43808;
    bad_count = 0;
    checks = 0;
    rstn = 1'b0;
    instr = '0;
    m_acc = ACCUM_RESET;
    m_z = 1'b0;
    m_dir = '{DIR_RESET, DIR_RESET, DIR_RESET};
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    issue(1, OP_XOR_LITERAL_ACCUM, 1, 7'h00, 8'h00, 8'h5a);
    issue(1, OP_SWAP_NIBBLES_FILE, 1, 7'h7f, 8'h00, 8'h3c);
    issue(1, OP_SWAP_NIBBLES_FILE, 0, 7'h00, 8'h00, 8'h12);
    for (int i = 4; i < 8; i++) begin
      issue(1, OP_XOR_LITERAL_ACCUM, 0, 7'h00, 8'(i * 17), 8'h00);
      issue(1, OP_LOAD_DIRECTION_REG, 0, 7'(i), 8'h00, 8'h00);
    end
    issue(0, OP_OR_ACCUM_WITH_FILE, 0, 7'h01, 8'h00, 8'hff);
    issue(1, OP_NONE, 1, 7'h01, 8'h00, 8'hff);
    issue(1, OP_XOR_ACCUM_WITH_FILE, 1, 7'h40, 8'h00, m_acc);
    issue(1, OP_OR_ACCUM_WITH_FILE, 1, 7'h00, 8'h00, 8'h00);
    $display("Test 1 corners done");
    repeat (300) begin
      r = $random(seed);
      issue(r[7] | r[15], op_t'(r[2:0] % 3'd6), r[3],
            r[11] ? {4'h0, r[14:12]} : r[22:16],
            r[10] ? m_acc : r[31:24],
            r[9] ? r[31:24] : (r[8] ? m_acc : 8'h00));
    end
    $display("Test 2 random mix done");
    repeat (3) issue(0, OP_NONE, 0, 7'h00, 8'h00, 8'h00);
    finish_test();
  end

  // Run needs about 325 cycles; allow far more
  initial begin
    #(25 * 5000);
    bad_count++;
    finish_test();
  end
endmodule
